// ### design/fpuxs_pkg.sv
/*
  Constants for the floating-point exception signalling block: register
  offsets, field positions, reset values and instruction class codes.
  Assumes a 32-bit APB register bus and one 250 MHz clock.
*/
package fpuxs_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS    = 8'h00;  // Control word (masks)
  localparam logic [7:0] STAT_OFS    = 8'h04;  // Status word
  localparam logic [7:0] SYSCTL_OFS  = 8'h08;  // System control register
  localparam logic [7:0] IRQST_OFS   = 8'h0C;  // Interrupt status, read clears
  localparam logic [7:0] IRQMSK_OFS  = 8'h10;  // Interrupt mask

  // Field positions
  localparam int NUM_EXC     = 6;   // Six exception classes
  localparam int INV_BIT     = 0;   // Invalid operation flag and mask
  localparam int SF_BIT      = 6;   // Stack fault flag
  localparam int ES_BIT      = 7;   // Exception summary flag
  localparam int C1_BIT      = 9;   // Condition bit one
  localparam int NE_BIT      = 0;   // Numeric error mode bit
  localparam int IRQ_FAULT   = 0;   // Event: fault raised
  localparam int IRQ_ERROUT  = 1;   // Event: error output rose
  localparam int IRQ_MASKED  = 2;   // Event: masked response given
  localparam int NUM_IRQ     = 3;   // Interrupt event count

  // Reset values
  localparam logic [5:0] MASK_RST    = 6'h3F;  // All exceptions masked
  localparam logic       NE_RST      = 1'h0;   // Compatibility mode
  localparam logic [2:0] IRQMSK_RST  = 3'h0;   // Interrupts gated off

  // Fault vector
  localparam logic [7:0] FAULT_VEC   = 8'h10;  // Vector 16

  // Instruction classes on the issue port
  localparam logic [2:0] K_ARITH     = 3'h0;  // Arithmetic, waiting
  localparam logic [2:0] K_NONARITH  = 3'h1;  // Non-arithmetic, waiting
  localparam logic [2:0] K_WAIT      = 3'h2;  // Wait instruction
  localparam logic [2:0] K_MEDIA     = 3'h3;  // Multimedia instruction
  localparam logic [2:0] K_NWCLEAR   = 3'h4;  // Non-waiting clear exceptions
  localparam logic [2:0] K_NWINIT    = 3'h5;  // Non-waiting initialise
  localparam logic [2:0] K_NWSTORE   = 3'h6;  // Non-waiting store of state

  // Issue sequencer states, one-hot
  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b001,
    ST_STALL = 3'b010,
    ST_RESP  = 3'b100
  } fpuxs_state_t;
endpackage

// ### design/fpuxs_sync2.sv
/*
  Two flip-flop synchroniser for one level.
  Assumes an asynchronous active-low reset; output resets to the
  given constant value chosen by the instance through its parameter.
*/
`timescale 1ns/1ps
module fpuxs_sync2 #(
  parameter logic RST_VAL = 1'b0              // Level during reset
) (
  input  wire logic clk,                      // Sampling clock
  input  wire logic rstN,                     // Async reset, active low
  input  wire logic din,                      // Level from another domain
  output logic      dout                      // Synchronised level
);
  logic stage1Q;                              // Metastable stage, read only below

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      stage1Q <= RST_VAL;
      dout    <= RST_VAL;
    end
    else
    begin
      stage1Q <= din;
      dout    <= stage1Q;
    end
  end
endmodule

// ### design/fpuxs_top.sv
/*
  Floating-point exception signalling unit: sticky flags, masks, summary
  flag, native fault request and compatibility error output with stall.
  Assumes the issue port is driven by pipeline logic on ref_clk, that the
  ignore input is an asynchronous pin, and APB on the same clock.
*/
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module fpuxs_top (
  input  wire logic        ref_clk,          // 250 MHz clock
  input  wire logic        nrst,             // Async reset, active low
  input  wire logic        psel,             // APB select
  input  wire logic        penable,          // APB access phase
  input  wire logic        pwrite,           // APB write
  input  wire logic [7:0]  paddr,            // APB byte address
  input  wire logic [31:0] pwdata,           // APB write data
  output logic      [31:0] prdata,           // APB read data
  output logic             pready,           // APB ready
  output logic             pslverr,          // APB error, unmapped
  input  wire logic        instrReq,         // Instruction waits to issue
  input  wire logic [2:0]  instrKind,        // Instruction class
  input  wire logic [5:0]  excDetect,        // Detected exception classes
  input  wire logic        stackFault,       // Register-stack fault detected
  input  wire logic        stackOverflow,    // Stack fault was overflow
  input  wire logic        ignoreErrorN,     // Ignore-error pin, active low
  output logic             instrDone,        // Pulse: request finished
  output logic             defaultResult,    // Pulse: use default result
  output logic             floatErrorFault,  // Pulse: fault instead of issue
  output logic      [7:0]  faultVector,      // Vector with the fault
  output logic             issueStall,       // Level: frozen before issue
  output logic             floatErrorOutN,   // Error output, active low
  output logic             irq               // Level interrupt
);
  // Reset release and pin capture
  logic rstN;                                // Synchronised reset
  logic ignSync;                             // Ignore input, active high
  logic ignRawN;                             // Ignore pin after two flops

  fpuxs_sync2 #(.RST_VAL(1'b0)) uRst (
    .clk  (ref_clk),
    .rstN (nrst),
    .din  (1'b1),
    .dout (rstN)
  );

  fpuxs_sync2 #(.RST_VAL(1'b1)) uIgn (
    .clk  (ref_clk),
    .rstN (nrst),
    .din  (ignoreErrorN),
    .dout (ignRawN)
  );

  assign ignSync = ~ignRawN;

  // State registers
  fpuxs_pkg::fpuxs_state_t stateQ, stateD;  // Issue sequencer
  logic [5:0]  maskQ;                       // Control word masks
  logic [5:0]  flagsQ, flagsD;              // Sticky exception flags
  logic        sfQ, sfD;                    // Stack fault flag
  logic        esQ, esD;                    // Exception summary flag
  logic        c1Q, c1D;                    // Condition bit one
  logic        neModeQ;                     // Numeric error mode bit
  logic [2:0]  irqStQ, irqStD;              // Sticky interrupt events
  logic [2:0]  irqMskQ;                     // Interrupt mask
  wire         errOutNow = ~floatErrorOutN; // Error output, active high

  // APB decode
  wire         setupPh = psel & ~penable;
  // Only the ready cycle acts, a stretched access cannot repeat a write
  wire         accWr   = psel & penable & pready & pwrite;
  wire         accRd   = psel & penable & pready & ~pwrite;
  wire         hitCtrl = (paddr == fpuxs_pkg::CTRL_OFS);
  wire         hitStat = (paddr == fpuxs_pkg::STAT_OFS);
  wire         hitSys  = (paddr == fpuxs_pkg::SYSCTL_OFS);
  wire         hitIrqS = (paddr == fpuxs_pkg::IRQST_OFS);
  wire         hitIrqM = (paddr == fpuxs_pkg::IRQMSK_OFS);
  wire         mapped  = hitCtrl | hitStat | hitSys | hitIrqS | hitIrqM;
  wire         wrCtrl  = accWr & hitCtrl;
  wire         wrStat  = accWr & hitStat;
  wire         wrSys   = accWr & hitSys;
  wire         wrIrqM  = accWr & hitIrqM;
  wire         rdIrqS  = accRd & hitIrqS;
  wire  [31:0] statWord = {22'h0, c1Q, 1'b0, esQ, sfQ, flagsQ};
  wire  [31:0] rdMux   = hitCtrl ? {26'h0, maskQ} :
                         hitStat ? statWord :
                         hitSys  ? {31'h0, neModeQ} :
                         hitIrqS ? {29'h0, irqStQ} :
                         hitIrqM ? {29'h0, irqMskQ} : 32'h0;

  // Instruction classification
  wire kArith   = (instrKind == fpuxs_pkg::K_ARITH);
  wire kNonAr   = (instrKind == fpuxs_pkg::K_NONARITH);
  wire kClear   = (instrKind == fpuxs_pkg::K_NWCLEAR);
  wire kInit    = (instrKind == fpuxs_pkg::K_NWINIT);
  // Waiting kinds sit below the non-waiting codes
  wire kWaiting = (instrKind <= fpuxs_pkg::K_MEDIA);

  // Pending summary decides what happens at issue
  wire inIdle     = (stateQ == fpuxs_pkg::ST_IDLE);
  wire inStall    = (stateQ == fpuxs_pkg::ST_STALL);
  wire nativeHit  = esQ & neModeQ & kWaiting;
  // compatibility freeze unless ignore is held
  wire compatHold = esQ & ~neModeQ & kWaiting & ~ignSync;
  wire takeFault  = inIdle & instrReq & nativeHit;
  wire execNow    = inIdle & instrReq & ~nativeHit & ~compatHold;

  // arithmetic classes only from arithmetic instructions
  wire [5:0] arFlags  = kArith ? excDetect : 6'h0;
  wire       stkHit   = execNow & (kArith | kNonAr) & stackFault;
  wire [5:0] newFlags = (execNow ? arFlags : 6'h0)
                        | (stkHit ? 6'h01 : 6'h0);
  // mask one masks, mask zero unmasks
  wire [5:0] unmasked = newFlags & ~maskQ;
  wire [5:0] masked   = newFlags & maskQ;
  wire       clrExec  = execNow & (kClear | kInit);
  wire       stWrite  = wrStat;
  wire [5:0] flagClr  = (clrExec ? 6'h3F : 6'h0) | (stWrite ? pwdata[5:0] : 6'h0);
  // error output wanted while summary stands in compatibility mode and ignore is not held
  wire       errWant  = esQ & ~neModeQ & ~ignSync;

  always_comb
  begin
    flagsD = (flagsQ & ~flagClr) | newFlags;
    sfD    = (sfQ & ~(clrExec | (stWrite & pwdata[fpuxs_pkg::SF_BIT]))) | stkHit;
    // unmasked sets summary in either mode
    esD    = (esQ & ~(clrExec | (stWrite & pwdata[fpuxs_pkg::ES_BIT]))) | (|unmasked);
    c1D    = stkHit ? stackOverflow
           : ((stWrite & pwdata[fpuxs_pkg::C1_BIT]) ? 1'b0 : c1Q);
  end

  // Sequencer next state
  always_comb
  begin
    case (stateQ)
      fpuxs_pkg::ST_IDLE:
      begin
        if (takeFault | execNow)
          stateD = fpuxs_pkg::ST_RESP;
        else if (instrReq & compatHold)
          stateD = fpuxs_pkg::ST_STALL;
        else
          stateD = fpuxs_pkg::ST_IDLE;
      end
      // Leave once the handler cleared the summary
      fpuxs_pkg::ST_STALL:
        stateD = (instrReq & compatHold) ? fpuxs_pkg::ST_STALL : fpuxs_pkg::ST_IDLE;
      // Gap so a held request is not taken twice
      fpuxs_pkg::ST_RESP:
        stateD = fpuxs_pkg::ST_IDLE;
      default:
        stateD = fpuxs_pkg::ST_IDLE;
    endcase
  end

  // Interrupt events, set beats the read clear
  always_comb
  begin
    // Clear only what the read reported, a later event must not be lost
    irqStD = rdIrqS ? (irqStQ & ~prdata[2:0]) : irqStQ;
    irqStD[fpuxs_pkg::IRQ_FAULT]  = irqStD[fpuxs_pkg::IRQ_FAULT] | takeFault;
    irqStD[fpuxs_pkg::IRQ_ERROUT] = irqStD[fpuxs_pkg::IRQ_ERROUT] | (errWant & ~errOutNow);
    irqStD[fpuxs_pkg::IRQ_MASKED] = irqStD[fpuxs_pkg::IRQ_MASKED] | (|masked);
  end

  // Exception state
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      stateQ <= fpuxs_pkg::ST_IDLE;
      flagsQ <= 6'h0;
      sfQ    <= 1'b0;
      esQ    <= 1'b0;
      c1Q    <= 1'b0;
    end
    else
    begin
      stateQ <= stateD;
      flagsQ <= flagsD;
      sfQ    <= sfD;
      esQ    <= esD;
      c1Q    <= c1D;
    end
  end

  // Software writable configuration
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      maskQ   <= fpuxs_pkg::MASK_RST;
      neModeQ <= fpuxs_pkg::NE_RST;
      irqMskQ <= fpuxs_pkg::IRQMSK_RST;
      irqStQ  <= 3'h0;
    end
    else
    begin
      // Initialise restores all masks
      if (execNow & kInit)
        maskQ <= fpuxs_pkg::MASK_RST;
      else if (wrCtrl)
        maskQ <= pwdata[5:0];
      if (wrSys)
        neModeQ <= pwdata[fpuxs_pkg::NE_BIT];
      if (wrIrqM)
        irqMskQ <= pwdata[2:0];
      irqStQ <= irqStD;
    end
  end

  // Issue port answers, all registered
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      instrDone       <= 1'b0;
      defaultResult   <= 1'b0;
      floatErrorFault <= 1'b0;
      faultVector     <= 8'h00;
      floatErrorOutN  <= 1'b1;
      irq             <= 1'b0;
    end
    else
    begin
      instrDone       <= takeFault | execNow;
      defaultResult   <= |masked;
      // fault goes to the normal exception path
      floatErrorFault <= takeFault;
      faultVector     <= takeFault ? fpuxs_pkg::FAULT_VEC : 8'h00;
      // ignore input drops it three edges after the pin: two synchroniser flops, then this register
      floatErrorOutN  <= ~errWant;
      irq             <= |(irqStD & irqMskQ);
    end
  end

  assign issueStall     = stateQ[1];

  // APB slave, answers in the first access cycle
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= setupPh;
      pslverr <= setupPh & ~mapped;
      prdata  <= (setupPh & ~pwrite) ? rdMux : 32'h0;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstN);

  AST_MASKED_DEFAULT: assert property (
    execNow && kArith && !stackFault && excDetect != 6'h0 && (excDetect & ~maskQ) == 6'h0 && !esQ
    |=> defaultResult && instrDone && !floatErrorFault && !esQ)
    else $error("masked exception did not give default result");

  AST_STICKY: assert property (
    !stWrite && !clrExec |=> (flagsQ & $past(flagsQ)) == $past(flagsQ))
    else $error("sticky flag lost without a clear");

  AST_NONARITH: assert property (
    execNow && kNonAr && !stWrite |=> flagsQ[5:1] == $past(flagsQ[5:1]))
    else $error("non-arithmetic instruction set an arithmetic flag");

  AST_NATIVE_FAULT: assert property (
    inIdle && instrReq && kWaiting && esQ && neModeQ
    |=> floatErrorFault && instrDone && faultVector == 8'h10 ##1 !floatErrorFault)
    else $error("native fault not raised with vector 16");

  AST_NOWAIT_RUNS: assert property (
    inIdle && instrReq && !kWaiting |=> instrDone && !floatErrorFault)
    else $error("non-waiting instruction was blocked");

  AST_COMPAT_STALL: assert property (
    inIdle && instrReq && kWaiting && esQ && !neModeQ && !ignSync
    |=> issueStall && !instrDone)
    else $error("compatibility mode did not freeze");

  AST_ERROUT_HOLD: assert property (
    esQ && !neModeQ && !ignSync |=> !floatErrorOutN)
    else $error("error output not held while summary set");

  AST_ERROUT_RELEASE: assert property (
    !esQ |=> floatErrorOutN)
    else $error("error output stayed after summary cleared");

  AST_MODE_COMPAT: assert property (
    !neModeQ |=> !floatErrorFault)
    else $error("fault raised in compatibility mode");

  AST_MASK_ONE: assert property (
    execNow && kArith && !stackFault && (excDetect & maskQ) != 6'h0 |=> defaultResult)
    else $error("masked class gave no default result");

  AST_INVALID_BIT0: assert property (
    execNow && kArith && !stackFault && excDetect == 6'h01 && !maskQ[0] |=> esQ && flagsQ[0])
    else $error("unmasked invalid at bit 0 missed summary");

  AST_IGNORE: assert property (
    ignSync |=> floatErrorOutN)
    else $error("error signalled while ignore input asserted");

  AST_STACK_FAULT: assert property (
    stkHit |=> flagsQ[0] && sfQ && c1Q == $past(stackOverflow))
    else $error("stack fault bits not set");

  AST_SUMMARY: assert property (
    execNow && kArith && (excDetect & ~maskQ) != 6'h0
    |=> esQ && ((flagsQ & $past(excDetect)) == $past(excDetect)))
    else $error("unmasked exception missed flag or summary");

  AST_STALL_RELEASE: assert property (
    inStall && !esQ |=> inIdle ##1 (instrDone || !$past(instrReq)))
    else $error("stall not released after summary cleared");
endmodule

// ### testbench/fpuxs_pic_model.sv
/*
  Behavioural model of the cascaded interrupt controller that sits
  behind the active-low error output in compatibility mode.
  Assumes the bench acknowledges each interrupt that it has taken.
*/
`timescale 1ns/1ps
module fpuxs_pic_model (
  input  wire logic       ref_clk,  // Processor clock
  input  wire logic       nrst,     // Async reset, active low
  input  wire logic       errLineN, // Error output of the unit
  input  wire logic       intAck,   // Bench takes the interrupt
  output logic            intrReq,  // Maskable interrupt request level
  output logic      [7:0] intrVec   // Vector, valid only while requesting
);
  localparam logic [7:0] VEC_LINE13 = 8'h75; // Vector of request line 13
  logic       errSeenN_q; // Last sampled error level
  logic       pend_q;     // Request line 13 pending
  logic [7:0] junk_q;     // Changing pattern, idle bus is not held
  // Idle vector steps by 8'h35 through all 256 values, so it can equal the real one
  assign intrVec = pend_q ? VEC_LINE13 : junk_q;
  assign intrReq = pend_q;
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      errSeenN_q <= 1'b1;
      pend_q     <= 1'b0;
      junk_q     <= 8'h00;
    end
    else
    begin
      errSeenN_q <= errLineN;
      junk_q     <= junk_q + 8'h35;
      // Falling error line raises the request, ack drops it
      if (errSeenN_q && !errLineN)
        pend_q <= 1'b1;
      else if (intAck)
        pend_q <= 1'b0;
    end
  end
endmodule

// ### testbench/fpu_exception_signaling_tb.sv
/*
  Self-checking bench of the exception signalling unit: APB tasks,
  an issue-port driver and a controller model on the error output.
  Assumes the package constants and the hand-over timing of the unit.
*/
`timescale 1ns/1ps
module fpu_exception_signaling_tb;
  logic        ref_clk, nrst, psel, penable, pwrite, instrReq;
  logic [7:0]  paddr, faultVector, intrVec;
  logic [31:0] pwdata, prdata, rdv;
  logic [2:0]  instrKind;
  logic [5:0]  excDetect;
  logic        stackFault, stackOverflow, ignoreErrorN, intAck;
  logic        pready, pslverr, instrDone, defaultResult, floatErrorFault;
  logic        issueStall, floatErrorOutN, irq, intrReq, err, f, d;
  logic [7:0]  v;
  int          mismatches, checksDone;

  fpuxs_top dut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .instrReq(instrReq), .instrKind(instrKind),
    .excDetect(excDetect), .stackFault(stackFault), .stackOverflow(stackOverflow),
    .ignoreErrorN(ignoreErrorN), .instrDone(instrDone), .defaultResult(defaultResult),
    .floatErrorFault(floatErrorFault), .faultVector(faultVector),
    .issueStall(issueStall), .floatErrorOutN(floatErrorOutN), .irq(irq));
  fpuxs_pic_model pic (.ref_clk(ref_clk), .nrst(nrst), .errLineN(floatErrorOutN),
    .intAck(intAck), .intrReq(intrReq), .intrVec(intrVec));

  // 250 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Verdict and end of run
  task automatic testDone();
    $display("checks %0d mismatches %0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer, held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 20)
      mismatches++;
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rdv);
  endtask

  task automatic start(input logic [2:0] k, input logic [5:0] e, input logic sf,
                       input logic ov);
    @(posedge ref_clk);
    instrReq <= 1'b1;
    instrKind <= k;
    excDetect <= e;
    stackFault <= sf;
    stackOverflow <= ov;
  endtask

  // Wait for the done pulse, take its companions, then drop the request
  task automatic finish();
    int n;
    n = 0;
    @(posedge ref_clk);
    while (instrDone !== 1'b1 && n < 50)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 50)
      mismatches++;
    f = floatErrorFault;
    v = faultVector;
    d = defaultResult;
    instrReq <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic issue(input logic [2:0] k, input logic [5:0] e, input logic sf,
                       input logic ov, input logic fe, input logic de);
    start(k, e, sf, ov);
    finish();
    chk("fault", {31'h0, fe}, {31'h0, f});
    chk("vector", fe ? 32'h10 : 32'h0, {24'h0, v});
    chk("default", {31'h0, de}, {31'h0, d});
  endtask

  // Watchdog, far beyond the 150 or so cycles the tests need
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    testDone();
  end

  initial
  begin
    {nrst, psel, penable, pwrite, instrReq, stackFault, stackOverflow, intAck} = 8'h00;
    {paddr, pwdata, instrKind, excDetect} = 49'h0;
    ignoreErrorN = 1'b1;
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rdChk("ctrl", fpuxs_pkg::CTRL_OFS, 32'h3F);
    rdChk("mode", fpuxs_pkg::SYSCTL_OFS, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    $display("test reset done");
    // Masked responses accumulate
    issue(fpuxs_pkg::K_ARITH, 6'h12, 1'b0, 1'b0, 1'b0, 1'b1);
    issue(fpuxs_pkg::K_ARITH, 6'h20, 1'b0, 1'b0, 1'b0, 1'b1);
    issue(fpuxs_pkg::K_NONARITH, 6'h3F, 1'b1, 1'b1, 1'b0, 1'b1);
    rdChk("status", fpuxs_pkg::STAT_OFS, 32'h273);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b1, fpuxs_pkg::STAT_OFS, 32'h2FF);
    issue(fpuxs_pkg::K_NONARITH, 6'h00, 1'b1, 1'b0, 1'b0, 1'b1);
    rdChk("status", fpuxs_pkg::STAT_OFS, 32'h41);
    $display("test masked done");
    // Native mode, invalid unmasked
    apb(1'b1, fpuxs_pkg::SYSCTL_OFS, 32'h1);
    apb(1'b1, fpuxs_pkg::IRQMSK_OFS, 32'h7);
    rdChk("irqst", fpuxs_pkg::IRQST_OFS, 32'h4);
    apb(1'b1, fpuxs_pkg::CTRL_OFS, 32'h3E);
    apb(1'b1, fpuxs_pkg::STAT_OFS, 32'h2FF);
    issue(fpuxs_pkg::K_ARITH, 6'h03, 1'b0, 1'b0, 1'b0, 1'b1);
    rdChk("status", fpuxs_pkg::STAT_OFS, 32'h83);
    issue(fpuxs_pkg::K_NWSTORE, 6'h00, 1'b0, 1'b0, 1'b0, 1'b0);
    issue(fpuxs_pkg::K_WAIT, 6'h00, 1'b0, 1'b0, 1'b1, 1'b0);
    chk("irq", 32'h1, {31'h0, irq});
    issue(fpuxs_pkg::K_MEDIA, 6'h00, 1'b0, 1'b0, 1'b1, 1'b0);
    issue(fpuxs_pkg::K_NWCLEAR, 6'h00, 1'b0, 1'b0, 1'b0, 1'b0);
    rdChk("status", fpuxs_pkg::STAT_OFS, 32'h0);
    rdChk("irqst", fpuxs_pkg::IRQST_OFS, 32'h5);
    @(posedge ref_clk);
    chk("irq", 32'h0, {31'h0, irq});
    issue(fpuxs_pkg::K_NWINIT, 6'h00, 1'b0, 1'b0, 1'b0, 1'b0);
    rdChk("ctrl", fpuxs_pkg::CTRL_OFS, 32'h3F);
    $display("test native done");
    // Compatibility mode: error output, controller, stall
    apb(1'b1, fpuxs_pkg::SYSCTL_OFS, 32'h0);
    apb(1'b1, fpuxs_pkg::CTRL_OFS, 32'h3E);
    issue(fpuxs_pkg::K_ARITH, 6'h01, 1'b0, 1'b0, 1'b0, 1'b0);
    repeat (4) @(posedge ref_clk);
    chk("errout", 32'h0, {31'h0, floatErrorOutN});
    chk("maskable_interrupt_input", 32'h1, {31'h0, intrReq});
    chk("intvec", 32'h75, {24'h0, intrVec});
    intAck <= 1'b1;
    @(posedge ref_clk);
    intAck <= 1'b0;
    start(fpuxs_pkg::K_MEDIA, 6'h00, 1'b0, 1'b0);
    repeat (4) @(posedge ref_clk);
    chk("stall", 32'h1, {31'h0, issueStall});
    chk("errout", 32'h0, {31'h0, floatErrorOutN});
    apb(1'b1, fpuxs_pkg::STAT_OFS, 32'h81);
    finish();
    chk("fault", 32'h0, {31'h0, f});
    chk("errout", 32'h1, {31'h0, floatErrorOutN});
    rdChk("irqst", fpuxs_pkg::IRQST_OFS, 32'h2);
    $display("test compat done");
    // Ignore input held asserted
    ignoreErrorN <= 1'b0;
    repeat (4) @(posedge ref_clk);
    issue(fpuxs_pkg::K_ARITH, 6'h01, 1'b0, 1'b0, 1'b0, 1'b0);
    repeat (4) @(posedge ref_clk);
    chk("errout", 32'h1, {31'h0, floatErrorOutN});
    apb(1'b1, fpuxs_pkg::STAT_OFS, 32'h81);
    ignoreErrorN <= 1'b1;
    $display("test ignore done");
    testDone();
  end
endmodule
